// ### rtl/arfl_axil_slave.sv
// axi4-lite slave turning bus transfers into one-cycle register strobes
`timescale 1ns/1ps
module arfl_axil_slave import arfl_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [`ARFL_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ARFL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output arfl_req_t req,
  input wire logic [31:0] rdData,
  input wire logic rdErr,
  input wire logic wrErr
);
  logic [`ARFL_AW-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wrFire;
  logic arFire;

  // address and data are taken in either order; the write fires once both
  // are held and no response is still waiting
  assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign arFire = s_axi_arvalid && s_axi_arready;

  assign req.wr = wrFire;
  assign req.waddr = awAddr_q;
  assign req.wdata = wData_q;
  assign req.wstrb = wStrb_q;
  assign req.rd = arFire;
  assign req.raddr = s_axi_araddr;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      awAddr_q <= '0;
    end else if (wrFire) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awAddr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_wready <= 1'b1;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (wrFire) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ARFL_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrErr ? `ARFL_RESP_DECERR : `ARFL_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data is sampled on the accepting edge, so a clear-on-read takes
  // effect on the same edge the old value is captured
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `ARFL_RESP_OKAY;
    end else if (arFire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdData;
      s_axi_rresp <= rdErr ? `ARFL_RESP_DECERR : `ARFL_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### rtl/arfl_chan_flag.sv
// one channel: result word, end-of-conversion and overrun flags
`timescale 1ns/1ps
module arfl_chan_flag import arfl_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic store,
  input wire logic [`ARFL_DW-1:0] dataIn,
  input wire logic eocClr,
  input wire logic ovrClr,
  output logic [`ARFL_DW-1:0] data_q,
  output logic eoc_q,
  output logic ovr_q
);
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      data_q <= '0;
    end else if (store) begin
      data_q <= dataIn;
    end
  end

  // set is tested first so a coinciding read never hides a new result
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      eoc_q <= 1'b0;
    end else if (store) begin
      eoc_q <= 1'b1;
    end else if (eocClr) begin
      eoc_q <= 1'b0;
    end
  end

  // overrun needs the old flag still up; a stored result on a channel whose
  // flag was already read does not hold off the status-read clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ovr_q <= 1'b0;
    end else if (store && eoc_q) begin
      ovr_q <= 1'b1;
    end else if (ovrClr) begin
      ovr_q <= 1'b0;
    end
  end
endmodule

// ### rtl/arfl_map.svh
// register offsets, field positions, reset values and sizes of the flag block
`ifndef ARFL_MAP_SVH
`define ARFL_MAP_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define ARFL_NCH 8
`define ARFL_CW 3
`define ARFL_DW 10
`define ARFL_AW 8
`define ARFL_IW 3

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define ARFL_OFF_CHEN 8'h00
`define ARFL_OFF_CHDIS 8'h04
`define ARFL_OFF_CHSR 8'h08
`define ARFL_OFF_SR 8'h0c
`define ARFL_OFF_LAST_RESULT_REG 8'h10
`define ARFL_OFF_ISR 8'h14
`define ARFL_OFF_IMR 8'h18
`define ARFL_OFF_CDR0 8'h20
`define ARFL_OFF_CDR_END 8'h40

// ****************************************************************
// field positions
// ****************************************************************
`define ARFL_SR_EOC_LSB 0
`define ARFL_SR_OVR_LSB 8
`define ARFL_SR_RESULT_READY_FLAG_BIT 16
`define ARFL_SR_GOVR_BIT 17
`define ARFL_LAST_RESULT_REG_CHAN_LSB 16
`define ARFL_INT_STORE 0
`define ARFL_INT_OVR 1
`define ARFL_INT_GOVR 2

// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define ARFL_RST_CHEN 8'h00
`define ARFL_RST_IMR 3'h0
`define ARFL_RESP_OKAY 2'h0
`define ARFL_RESP_DECERR 2'h3

`endif

// ### rtl/arfl_pkg.sv
// types shared by the result flag block
package arfl_pkg;
  `include "arfl_map.svh"

  // one conversion end reported by the converter
  typedef struct packed {
    logic valid;
    logic [`ARFL_CW-1:0] chan;
    logic [`ARFL_DW-1:0] data;
  } arfl_conv_t;

  // register access strobes from the bus slave
  typedef struct packed {
    logic wr;
    logic [`ARFL_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic rd;
    logic [`ARFL_AW-1:0] raddr;
  } arfl_req_t;
endpackage

// ### rtl/arfl_result_flags.sv
// result path flag logic of the converter with its register slave
//
// Behaviour
// - only a last-result read clears result_ready_flag; channel reads leave it.
// - an end of conversion on a disabled channel never sets result_ready_flag.
// - a stored result sets result_ready_flag despite any other channel read.
// - disabling another channel at a store still stores and sets ready.
// - a status read at a conversion end still updates the global overrun.
// - status read clears global_overrun_flag unless a new overrun sets it.
// - a channel read at a store with ready already up sets the global overrun.
// - disabling another channel at a store still raises both overrun flags.
// - a channel's end flag clears on its own read or a matching last read.
// - a status read clears every channel_overrun_flag unless a new overrun sets it.
// - a channel disabled during conversion never raises its end flag.
// - a channel read clears only that channel's end flag.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module arfl_result_flags import arfl_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire arfl_conv_t conv,
  input wire logic [`ARFL_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ARFL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_q
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  arfl_req_t req;
  logic [31:0] rdData;
  logic rdErr;
  logic wrErr;
  logic [`ARFL_AW-1:0] wWord;
  logic [`ARFL_AW-1:0] rWord;
  logic wrByte0;
  logic [`ARFL_NCH-1:0] chenSet;
  logic [`ARFL_NCH-1:0] chdisSet;
  logic [`ARFL_NCH-1:0] chanEn_q;
  logic [`ARFL_NCH-1:0] chanLive;
  logic storeEv;
  logic lcdrRd;
  logic srRd;
  logic [`ARFL_NCH-1:0] cdrRd;
  logic [`ARFL_NCH-1:0] store;
  logic [`ARFL_NCH-1:0] eocClr;
  logic [`ARFL_NCH-1:0] eoc;
  logic [`ARFL_NCH-1:0] ovr;
  logic [`ARFL_DW-1:0] chData [`ARFL_NCH];
  logic [`ARFL_CW-1:0] lastChan_q;
  logic result_ready_flag_q;
  logic govr_q;
  logic govrSet;
  logic ovrSet;
  logic [`ARFL_IW-1:0] intEv;
  logic [`ARFL_IW-1:0] intClr;
  logic [`ARFL_IW-1:0] intStat_q;
  logic [`ARFL_IW-1:0] intStat_d;
  logic [`ARFL_IW-1:0] intMask_q;
  logic [`ARFL_IW-1:0] intMask_d;
  logic [`ARFL_CW-1:0] cdrIdx;
  logic cdrHit;
  logic [`ARFL_NCH-1:0] chanEn_d;
  logic wrChen;
  logic wrChdis;
  logic wrIsr;
  logic wrImr;
  logic [31:0] srWord;
  logic [31:0] lcdrWord;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  // rdData is captured on the edge that also fires the clear-on-read strobes
  arfl_axil_slave u_slave (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req),
    .rdData(rdData),
    .rdErr(rdErr),
    .wrErr(wrErr)
  );

  // low address bits are ignored: every register is one aligned word
  assign wWord = {req.waddr[`ARFL_AW-1:2], 2'h0};
  assign rWord = {req.raddr[`ARFL_AW-1:2], 2'h0};
  assign wrByte0 = req.wr && req.wstrb[0];

  // ****************************************************************
  // write strobes
  // ****************************************************************
  // only byte lane 0 holds writable bits, so the other lanes are dropped
  assign wrChen = wrByte0 && wWord == `ARFL_OFF_CHEN;
  assign wrChdis = wrByte0 && wWord == `ARFL_OFF_CHDIS;
  assign wrIsr = wrByte0 && wWord == `ARFL_OFF_ISR;
  assign wrImr = wrByte0 && wWord == `ARFL_OFF_IMR;

  // ****************************************************************
  // channel enables
  // ****************************************************************
  assign chenSet = wrChen ? req.wdata[`ARFL_NCH-1:0] : '0;
  assign chdisSet = wrChdis ? req.wdata[`ARFL_NCH-1:0] : '0;

  // a disable written in the cycle of the end of conversion already blocks
  // that channel, while the other channels are untouched
  assign chanLive = chanEn_q & ~chdisSet;

  // limitation: an enable acts from the next edge, so a result that arrives
  // in the cycle of its own enable write is still dropped
  assign chanEn_d = (chanEn_q | chenSet) & ~chdisSet;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      chanEn_q <= `ARFL_RST_CHEN;
    end else begin
      chanEn_q <= chanEn_d;
    end
  end

  // ****************************************************************
  // read strobes that clear flags
  // ****************************************************************
  assign lcdrRd = req.rd && rWord == `ARFL_OFF_LAST_RESULT_REG;
  assign srRd = req.rd && rWord == `ARFL_OFF_SR;

  // a result from a disabled channel is dropped: no data, no flags
  assign storeEv = conv.valid && chanLive[conv.chan];

  // ****************************************************************
  // per-channel result and flags
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `ARFL_NCH; gi++) begin : g_chan
      assign cdrRd[gi] = req.rd &&
        rWord == `ARFL_OFF_CDR0 + 8'(4 * gi);
      assign store[gi] = storeEv && conv.chan == `ARFL_CW'(gi);
      // each read strobe names its own channel only
      assign eocClr[gi] = cdrRd[gi] ||
        (lcdrRd && lastChan_q == `ARFL_CW'(gi));
      arfl_chan_flag u_flag (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .store(store[gi]),
        .dataIn(conv.data),
        .eocClr(eocClr[gi]),
        .ovrClr(srRd),
        .data_q(chData[gi]),
        .eoc_q(eoc[gi]),
        .ovr_q(ovr[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // last result pointer
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lastChan_q <= '0;
    end else if (storeEv) begin
      lastChan_q <= conv.chan;
    end
  end

  // ****************************************************************
  // global data ready
  // ****************************************************************
  // channel reads are deliberately absent from the clear term
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      result_ready_flag_q <= 1'b0;
    end else if (storeEv) begin
      result_ready_flag_q <= 1'b1;
    end else if (lcdrRd) begin
      result_ready_flag_q <= 1'b0;
    end
  end

  // ****************************************************************
  // global overrun
  // ****************************************************************
  // any stored result while ready is still up is a general overrun,
  // whatever read or disable happens in the same cycle
  assign govrSet = storeEv && result_ready_flag_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      govr_q <= 1'b0;
    end else if (govrSet) begin
      govr_q <= 1'b1;
    end else if (srRd) begin
      govr_q <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  // a channel overrun needs that channel's old end flag still up
  assign ovrSet = storeEv && |(eoc & store);

  always_comb begin
    intEv = '0;
    intEv[`ARFL_INT_STORE] = storeEv;
    intEv[`ARFL_INT_OVR] = ovrSet;
    intEv[`ARFL_INT_GOVR] = govrSet;
  end

  assign intClr = wrIsr ? req.wdata[`ARFL_IW-1:0] : '0;

  // write-one-to-clear; an event in the clearing cycle survives
  assign intStat_d = (intStat_q & ~intClr) | intEv;
  assign intMask_d = wrImr ? req.wdata[`ARFL_IW-1:0] : intMask_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      intStat_q <= '0;
    end else begin
      intStat_q <= intStat_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      intMask_q <= `ARFL_RST_IMR;
    end else begin
      intMask_q <= intMask_d;
    end
  end

  // built from next values so the pin follows status with no extra cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(intStat_d & intMask_d);
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  // writes to read-only words are ignored with an okay answer
  always_comb begin
    unique case (wWord)
      `ARFL_OFF_CHEN, `ARFL_OFF_CHDIS, `ARFL_OFF_CHSR, `ARFL_OFF_SR,
      `ARFL_OFF_LAST_RESULT_REG, `ARFL_OFF_ISR, `ARFL_OFF_IMR: begin
        wrErr = 1'b0;
      end
      default: begin
        wrErr = !(wWord >= `ARFL_OFF_CDR0 && wWord < `ARFL_OFF_CDR_END);
      end
    endcase
  end

  // ****************************************************************
  // read words
  // ****************************************************************
  always_comb begin
    srWord = '0;
    srWord[`ARFL_SR_EOC_LSB +: `ARFL_NCH] = eoc;
    srWord[`ARFL_SR_OVR_LSB +: `ARFL_NCH] = ovr;
    srWord[`ARFL_SR_RESULT_READY_FLAG_BIT] = result_ready_flag_q;
    srWord[`ARFL_SR_GOVR_BIT] = govr_q;
  end

  // before any store the pointer rests on channel 0, which reads as zero
  always_comb begin
    lcdrWord = '0;
    lcdrWord[`ARFL_DW-1:0] = chData[lastChan_q];
    lcdrWord[`ARFL_LAST_RESULT_REG_CHAN_LSB +: `ARFL_CW] = lastChan_q;
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  assign cdrHit = rWord >= `ARFL_OFF_CDR0 && rWord < `ARFL_OFF_CDR_END;
  assign cdrIdx = rWord[`ARFL_CW+1:2];

  always_comb begin
    rdData = '0;
    rdErr = 1'b0;
    unique case (rWord)
      `ARFL_OFF_CHEN, `ARFL_OFF_CHDIS: begin
        rdData = '0;
      end
      `ARFL_OFF_CHSR: begin
        rdData[`ARFL_NCH-1:0] = chanEn_q;
      end
      `ARFL_OFF_SR: begin
        rdData = srWord;
      end
      `ARFL_OFF_LAST_RESULT_REG: begin
        rdData = lcdrWord;
      end
      `ARFL_OFF_ISR: begin
        rdData[`ARFL_IW-1:0] = intStat_q;
      end
      `ARFL_OFF_IMR: begin
        rdData[`ARFL_IW-1:0] = intMask_q;
      end
      default: begin
        if (cdrHit) begin
          rdData[`ARFL_DW-1:0] = chData[cdrIdx];
        end else begin
          rdErr = 1'b1;
        end
      end
    endcase
  end
endmodule

// ### verification/arfl_result_flags_checker.sv
// port-level assertions for the result flag block
`timescale 1ns/1ps
`include "arfl_map.svh"
module arfl_result_flags_checker import arfl_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire arfl_conv_t conv,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ARFL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // *****
  // status history
  // *****
  logic arTake, rdIsSr, drdyHeld, convSince, convAcc;
  assign arTake = s_axi_arvalid && s_axi_arready;
  // a status read fixes which sticky bits the next one must still show
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdIsSr <= 1'h0;
      drdyHeld <= 1'h0;
      convSince <= 1'h1;
      convAcc <= 1'h0;
    end else begin
      if (arTake)
        rdIsSr <= s_axi_araddr == `ARFL_OFF_SR;
      if (s_axi_rvalid && s_axi_rready && rdIsSr)
        drdyHeld <= s_axi_rdata[`ARFL_SR_RESULT_READY_FLAG_BIT];
      else if (arTake && s_axi_araddr == `ARFL_OFF_LAST_RESULT_REG)
        drdyHeld <= 1'h0;
      // ends since the previous status read, its own edge included; the
      // data of this read predate its own edge
      if (arTake && s_axi_araddr == `ARFL_OFF_SR) begin
        convSince <= convAcc;
        convAcc <= conv.valid;
      end else if (conv.valid) begin
        convAcc <= 1'h1;
      end
    end
  end
  // *****
  // assertions
  // *****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (arTake |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answering");
  a_decerr_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == `ARFL_RESP_DECERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_ready_kept: assert property (s_axi_rvalid && rdIsSr && drdyHeld
    |-> s_axi_rdata[`ARFL_SR_RESULT_READY_FLAG_BIT]) else $error("ready flag lost");
  a_overrun_cleared: assert property (s_axi_rvalid && rdIsSr
    && !convSince |-> !s_axi_rdata[`ARFL_SR_GOVR_BIT])
    else $error("global overrun not cleared");
  a_chovr_cleared: assert property (s_axi_rvalid && rdIsSr
    && !convSince |-> s_axi_rdata[`ARFL_SR_OVR_LSB +: `ARFL_NCH] == 8'h00)
    else $error("channel overrun not cleared");
  c_sr_conv: cover property (arTake && s_axi_araddr == `ARFL_OFF_SR &&
    conv.valid);
  c_last_conv: cover property (arTake && s_axi_araddr == `ARFL_OFF_LAST_RESULT_REG &&
    conv.valid);
  c_refused: cover property (s_axi_rvalid &&
    s_axi_rresp == `ARFL_RESP_DECERR);
endmodule

// ### verification/arfl_result_flags_test.sv
// self-checking bench for the result flag block over its register bus
`timescale 1ns/1ps
`include "arfl_map.svh"
module arfl_result_flags_test import arfl_pkg::*; ;
  // *****
  // wiring
  // *****
  localparam logic [7:0] aEn = `ARFL_OFF_CHEN;
  localparam logic [7:0] aDis = `ARFL_OFF_CHDIS;
  localparam logic [7:0] aEnSt = `ARFL_OFF_CHSR;
  localparam logic [7:0] aSr = `ARFL_OFF_SR;
  localparam logic [7:0] aLast = `ARFL_OFF_LAST_RESULT_REG;
  localparam logic [7:0] aIsr = `ARFL_OFF_ISR;
  localparam logic [7:0] aImr = `ARFL_OFF_IMR;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  arfl_conv_t conv = '0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic arvalid = 1'h0;
  // both answer channels stay ready so no release can collide with a request
  logic bready = 1'h1;
  logic rready = 1'h1;
  logic awready, wready, bvalid, arready, rvalid, irqQ;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rv;
  int n_fail = 0;
  int tests_run = 0;

  always #4 sys_clk = ~sys_clk;

  arfl_result_flags uut (
    .sys_clk(sys_clk), .resetn(resetn), .conv(conv),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_q(irqQ)
  );

  // *****
  // tasks
  // *****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] channel_result_reg(input int i);
    return `ARFL_OFF_CDR0 + 8'(4 * i);
  endfunction

  // co puts a conversion end on the edge that takes the address
  task automatic rd(input logic [7:0] a, input logic co = 1'h0,
                    input logic [2:0] c = '0, input logic [9:0] v = '0);
    araddr <= a;
    arvalid <= 1'h1;
    if (co) conv <= '{1'h1, c, v};
    do @(posedge sys_clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    if (co) conv.valid <= 1'h0;
    do @(posedge sys_clk); while (rvalid !== 1'h1);
    rv = rdata;
    rs = rresp;
  endtask

  // co puts a conversion end on the edge where the write acts
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic co = 1'h0, input logic [2:0] c = '0,
                    input logic [9:0] v = '0);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'h1) aw = 1'h1;
      if (wready === 1'h1) w = 1'h1;
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end while (!(aw && w));
    if (co) begin
      conv <= '{1'h1, c, v};
      @(posedge sys_clk);
      conv.valid <= 1'h0;
    end
    do @(posedge sys_clk); while (bvalid !== 1'h1);
    rs = bresp;
  endtask

  task automatic cv(input logic [2:0] c, input logic [9:0] v);
    conv <= '{1'h1, c, v};
    @(posedge sys_clk);
    conv.valid <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // *****
  // sequence
  // *****
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    rdc(aEnSt, 32'h0);
    rdc(aImr, 32'h0);
    rdc(aIsr, 32'h0);
    wr(aEn, 32'hf);
    rdc(aEnSt, 32'hf);
    cv(3'h0, 10'h011);
    rdc(aSr, 32'h00010001);
    rdc(channel_result_reg(0), 32'h011);
    rdc(aSr, 32'h00010000);
    rdc(aLast, 32'h011);
    rdc(aSr, 32'h0);
    cv(3'h1, 10'h022);
    cv(3'h2, 10'h033);
    rdc(aSr, 32'h00030006);
    rdc(aSr, 32'h00010006);
    rdc(aLast, 32'h00020033);
    rd(channel_result_reg(3), 1'h1, 3'h1, 10'h044);
    rdc(aSr, 32'h00010202);
    cv(3'h0, 10'h055);
    rdc(aSr, 32'h00030003);
    rd(channel_result_reg(2), 1'h1, 3'h1, 10'h066);
    chk(rv, 32'h033);
    rdc(aSr, 32'h00030203);
    wr(aDis, 32'h8, 1'h1, 3'h0, 10'h077);
    rdc(aSr, 32'h00030103);
    rdc(aLast, 32'h077);
    rdc(aEnSt, 32'h7);
    wr(aDis, 32'h4, 1'h1, 3'h1, 10'h088);
    rdc(aSr, 32'h00010202);
    rdc(channel_result_reg(1), 32'h088);
    rd(aLast, 1'h1, 3'h3, 10'h099);
    chk(rv, 32'h00010088);
    rdc(aSr, 32'h0);
    rd(channel_result_reg(0), 1'h1, 3'h2, 10'h0aa);
    rdc(aSr, 32'h0);
    cv(3'h0, 10'h0b1);
    cv(3'h0, 10'h0b2);
    rdc(aLast, 32'h0b2);
    rd(aSr, 1'h1, 3'h0, 10'h0b3);
    chk(rv, 32'h00020100);
    rdc(aSr, 32'h00010001);
    rd(aSr, 1'h1, 3'h0, 10'h0b4);
    chk(rv, 32'h00010001);
    rdc(aSr, 32'h00030101);
    // interrupt: raise, mask, clear
    rdc(aIsr, 32'h7);
    chk(irqQ, 32'h0);
    wr(aImr, 32'h2);
    rdc(aImr, 32'h2);
    chk(irqQ, 32'h1);
    wr(aIsr, 32'h2);
    rdc(aIsr, 32'h5);
    chk(irqQ, 32'h0);
    // refused and ignored accesses
    rd(8'h1c);
    chk(rv, 32'h0);
    chk(rs, `ARFL_RESP_DECERR);
    wr(8'h1c, 32'h1);
    chk(rs, `ARFL_RESP_DECERR);
    wr(aSr, 32'hffffffff);
    chk(rs, `ARFL_RESP_OKAY);
    rdc(aSr, 32'h00010001);
    conclude();
  end

  // the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule

bind arfl_result_flags arfl_result_flags_checker chk_i (
  .sys_clk(sys_clk), .resetn(resetn), .conv(conv),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
